//--- hdl/wcm_regs.vh
// Register map, field positions, reset values and burst counts
`ifndef WCM_REGS_VH
`define WCM_REGS_VH

`define WCM_ADDR_CTRL 8'h00
`define WCM_ADDR_STATUS 8'h04
`define WCM_ADDR_CRC_CALC 8'h08
`define WCM_ADDR_CRC_RECV 8'h0c

`define WCM_CTRL_CRC_EN 0
`define WCM_CTRL_BC4_FIXED 1
`define WCM_CTRL_MASK_EN 2
`define WCM_CTRL_INV_EN 3
`define WCM_CTRL_X16 4
`define WCM_CTRL_RESET 5'h00

`define WCM_STAT_ERR_LO 0
`define WCM_STAT_ERR_HI 1
`define WCM_STAT_BUSY 2

`define WCM_BEAT_CHECK 4'h8
`define WCM_BEAT_LAST 4'h9
`define WCM_DATA_BEATS 4
`define WCM_CRC_POLY 8'h07

`endif

//--- hdl/wcm_write_crc_mapper.v
// Write CRC input mapper and checker for burst-chop-four writes
`timescale 1ns/1ps
`include "wcm_regs.vh"

// How it works
// R1: Byte-wide mode feeds 32 data bits, others one
// R2: Lane n beats 0-3 fill bits 8n..8n+3
// R3: Low select takes mask nibble only if enabled
// R4: High select moves data to upper nibbles
// R5: High select mask nibble 68-71 only if enabled
// R6: Sixteen-bit mode uses two identical trees
// R7: Upper lanes start at bit 72, check 8-15
// R8: Low select mask nibbles 64-67, 136-139 gated
// R9: High select upper lanes map to upper nibble
// R10: High select mask nibbles 68-71, 140-143 gated
// R11: Lower check over 0-71, upper over 72-143
// R12: Select latched with write picks first nibble
// R13: Each tree makes eight-bit check from 72 inputs
// R14: Mismatch starts error signalling
// R15: Mapping only with CRC on and fixed chop
module wcm_write_crc_mapper
(
    input wire clk,
    input wire sys_rst,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [31:0] reg_rdata,
    input wire write_cmd,
    input wire critical_nibble_select,
    input wire link_strobe,
    input wire [15:0] link_dq,
    input wire lower_mask_inversion_lane,
    input wire upper_mask_inversion_lane,
    output reg crc_error,
    output reg [15:0] crc_calc
);

    // ********************************************
    // Burst states
    // ********************************************
    localparam ST_IDLE = 2'b00;
    localparam ST_BEATS = 2'b01;
    localparam ST_CHECK = 2'b10;

    // ********************************************
    // Check-value function
    // ********************************************
    // Serial form of the eight-bit tree; bit 71 enters first
    function [7:0] wcm_crc8;
        input [71:0] d;
        integer i;
        reg [7:0] c;
        reg fb;
        begin
            c = 8'h00;
            fb = 1'b0;
            for (i = 71; i >= 0; i = i - 1)
            begin
                fb = c[7] ^ d[i];
                c = {c[6:0], 1'b0} ^ ({8{fb}} & `WCM_CRC_POLY);
            end
            wcm_crc8 = c;
        end
    endfunction

    // ********************************************
    // Registers and state
    // ********************************************
    reg [4:0] ctrl;
    reg err_lo;
    reg err_hi;
    reg [15:0] crc_recv;
    reg [1:0] state;
    reg [3:0] beat;
    reg nibble_high;
    reg mode_x16;
    reg lanes_en;
    reg [71:0] nib_store;
    reg strobe_s1;
    reg strobe_s2;
    reg strobe_s3;
    reg [17:0] lane_s1;
    reg [17:0] lane_s2;
    reg [31:0] next_rdata;

    wire crc_en;
    wire bc4_fixed;
    wire mapping_on;
    wire strobe_rise;
    wire [17:0] lane_vec;
    wire [143:0] tree;
    wire [7:0] calc_lo;
    wire [7:0] calc_hi;
    wire mism_lo;
    wire mism_hi;
    wire clr_lo;
    wire clr_hi;

    assign crc_en = ctrl[`WCM_CTRL_CRC_EN];
    assign bc4_fixed = ctrl[`WCM_CTRL_BC4_FIXED];
    assign mapping_on = crc_en & bc4_fixed; // [R15]

    // ********************************************
    // Link input synchronisers
    // ********************************************
    // Lanes in tree-byte order: dq 0-7, lower mask, dq 8-15, upper mask
    assign lane_vec = {upper_mask_inversion_lane, link_dq[15:8],
        lower_mask_inversion_lane, link_dq[7:0]};

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            strobe_s1 <= 1'b0;
            strobe_s2 <= 1'b0;
            strobe_s3 <= 1'b0;
            lane_s1 <= 18'h3ffff;
            lane_s2 <= 18'h3ffff;
        end
        else
        begin
            strobe_s1 <= link_strobe;
            strobe_s2 <= strobe_s1;
            strobe_s3 <= strobe_s2;
            lane_s1 <= lane_vec;
            lane_s2 <= lane_s1;
        end
    end

    // Data and strobe share the same two-stage delay, so lanes
    // are stable around the detected edge at this strobe rate
    assign strobe_rise = strobe_s2 & ~strobe_s3;

    // ********************************************
    // Beat capture
    // ********************************************
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            state <= ST_IDLE;
            beat <= 4'h0;
            nibble_high <= 1'b0;
            mode_x16 <= 1'b0;
            lanes_en <= 1'b0;
            crc_recv <= 16'h0000;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    beat <= 4'h0;
                    if (write_cmd && mapping_on) // [R15]
                    begin
                        state <= ST_BEATS;
                        nibble_high <= critical_nibble_select; // [R12]
                        mode_x16 <= ctrl[`WCM_CTRL_X16];
                        lanes_en <= ctrl[`WCM_CTRL_MASK_EN] |
                            ctrl[`WCM_CTRL_INV_EN];
                    end
                end
                ST_BEATS:
                begin
                    if (strobe_rise)
                    begin
                        // Beats 4-7 and 9 carry padding ones; ignored
                        if (beat == `WCM_BEAT_CHECK)
                        begin
                            crc_recv <= {lane_s2[16:9], lane_s2[7:0]};
                        end
                        if (beat == `WCM_BEAT_LAST)
                        begin
                            state <= ST_CHECK;
                        end
                        beat <= beat + 4'h1;
                    end
                end
                ST_CHECK:
                begin
                    state <= ST_IDLE;
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ********************************************
    // Nibble store and tree mapping
    // ********************************************
    genvar j;
    genvar b;
    generate
        for (j = 0; j < 18; j = j + 1)
        begin : g_byte
            for (b = 0; b < `WCM_DATA_BEATS; b = b + 1)
            begin : g_beat
                always @(posedge clk)
                begin
                    if (sys_rst)
                    begin
                        nib_store[4*j+b] <= 1'b1;
                    end
                    else if (state == ST_BEATS && strobe_rise &&
                        beat == b)
                    begin
                        nib_store[4*j+b] <= lane_s2[j]; // [R2] [R7]
                    end
                end
            end
            if (j == 8 || j == 17)
            begin : g_mask
                // Mask nibble only counts while masking or inversion on
                wire [3:0] nib;
                assign nib = lanes_en ? nib_store[4*j+3:4*j] :
                    4'hf; // [R3] [R5] [R8] [R10]
                assign tree[8*j+7:8*j] = nibble_high ? {nib, 4'hf} :
                    {4'hf, nib}; // [R4] [R9]
            end
            else
            begin : g_data
                // 4 data bits per byte; the other nibble is forced high
                assign tree[8*j+7:8*j] = nibble_high ?
                    {nib_store[4*j+3:4*j], 4'hf} :
                    {4'hf, nib_store[4*j+3:4*j]}; // [R1] [R4] [R9]
            end
        end
    endgenerate

    // ********************************************
    // Check trees and compare
    // ********************************************
    // Two identical trees; the upper one only matters in x16 mode
    assign calc_lo = wcm_crc8(tree[71:0]); // [R11] [R13]
    assign calc_hi = wcm_crc8(tree[143:72]); // [R6] [R11] [R13]
    assign mism_lo = calc_lo != crc_recv[7:0];
    assign mism_hi = mode_x16 && (calc_hi != crc_recv[15:8]);

    assign clr_lo = reg_write && reg_addr == `WCM_ADDR_STATUS &&
        reg_wdata[`WCM_STAT_ERR_LO];
    assign clr_hi = reg_write && reg_addr == `WCM_ADDR_STATUS &&
        reg_wdata[`WCM_STAT_ERR_HI];

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            crc_error <= 1'b0;
            crc_calc <= 16'h0000;
            err_lo <= 1'b0;
            err_hi <= 1'b0;
        end
        else
        begin
            crc_error <= (state == ST_CHECK) &&
                (mism_lo || mism_hi); // [R14]
            if (state == ST_CHECK)
            begin
                crc_calc <= {mode_x16 ? calc_hi : 8'h00, calc_lo};
            end
            // A new error wins over a clear in the same cycle
            if (state == ST_CHECK && mism_lo)
            begin
                err_lo <= 1'b1; // [R14]
            end
            else if (clr_lo)
            begin
                err_lo <= 1'b0;
            end
            if (state == ST_CHECK && mism_hi)
            begin
                err_hi <= 1'b1; // [R14]
            end
            else if (clr_hi)
            begin
                err_hi <= 1'b0;
            end
        end
    end

    // ********************************************
    // Register port
    // ********************************************
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            ctrl <= `WCM_CTRL_RESET;
        end
        else if (reg_write && reg_addr == `WCM_ADDR_CTRL)
        begin
            // Mode changes apply from the next write command only
            ctrl <= reg_wdata[4:0];
        end
    end

    always @*
    begin
        next_rdata = 32'h00000000;
        case (reg_addr)
            `WCM_ADDR_CTRL:
            begin
                next_rdata[4:0] = ctrl;
            end
            `WCM_ADDR_STATUS:
            begin
                next_rdata[`WCM_STAT_ERR_LO] = err_lo;
                next_rdata[`WCM_STAT_ERR_HI] = err_hi;
                next_rdata[`WCM_STAT_BUSY] = state != ST_IDLE;
            end
            `WCM_ADDR_CRC_CALC:
            begin
                next_rdata[15:0] = crc_calc;
            end
            `WCM_ADDR_CRC_RECV:
            begin
                next_rdata[15:0] = crc_recv;
            end
            default:
            begin
                next_rdata = 32'h00000000;
            end
        endcase
    end

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            reg_rdata <= 32'h00000000;
        end
        else if (reg_read)
        begin
            reg_rdata <= next_rdata;
        end
        else
        begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule

//--- testbench/test_write_crc_bc4_input_mapper.sv
// Self-checking bench for the chopped-burst write CRC mapper
`timescale 1ns/1ps
`include "wcm_regs.vh"
module test_write_crc_bc4_input_mapper;
    // ****************
    // Set-up
    // ****************
    localparam [39:0] CTRL_TAB = 40'h02_17_13_0b_07;
    localparam [4:0] SEL_TAB = 5'h0a;
    localparam [9:0] BAD_TAB = 10'h184;
    reg clk = 1'b0, sys_rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
    reg write_cmd = 1'b0, critical_nibble_select = 1'b0;
    reg [7:0] reg_addr = 8'h00;
    reg [31:0] reg_wdata = 32'h0;
    wire [31:0] reg_rdata;
    wire link_strobe, lower_mask_inversion_lane, upper_mask_inversion_lane;
    wire crc_error;
    wire [15:0] link_dq, crc_calc;
    integer num_errors = 0, n_compared = 0, err_seen = 0;
    integer k, b, n, err0;
    reg [143:0] tree;
    reg [179:0] bv;
    reg [15:0] dq, chk, prev;
    reg [7:0] ctl, lo, hi;
    reg [31:0] v;
    reg [1:0] bad;
    reg sel, en;
    always #2.5 clk = ~clk;
    always @(posedge clk) if (crc_error === 1'b1) err_seen <= err_seen + 1;
    wcm_write_crc_mapper dut_u (.clk(clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .write_cmd(write_cmd),
        .critical_nibble_select(critical_nibble_select),
        .link_strobe(link_strobe), .link_dq(link_dq),
        .lower_mask_inversion_lane(lower_mask_inversion_lane),
        .upper_mask_inversion_lane(upper_mask_inversion_lane),
        .crc_error(crc_error), .crc_calc(crc_calc));
    wcm_ctrl_model model_u (.link_strobe(link_strobe), .link_dq(link_dq),
        .lower_mask_inversion_lane(lower_mask_inversion_lane),
        .upper_mask_inversion_lane(upper_mask_inversion_lane));
    task wr(input [7:0] a, input [31:0] d);
    begin
        @(posedge clk);
        {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
        @(posedge clk);
        reg_write <= 1'b0;
    end
    endtask
    task rd(input [7:0] a, output [31:0] d);
    begin
        @(posedge clk);
        {reg_addr, reg_read} <= {a, 1'b1};
        @(posedge clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
    begin
        n_compared = n_compared + 1;
        if (seen !== exp)
        begin
            num_errors = num_errors + 1;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    end
    endtask
    task report_and_stop;
    begin
        $display("errors %0d compares %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    // Serial check value, top tree bit first
    function [7:0] crc8(input [71:0] t);
        integer i;
        reg [7:0] c;
    begin
        c = 8'h00;
        for (i = 71; i >= 0; i = i - 1)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ t[i]) ? 8'h07 : 8'h00);
        crc8 = c;
    end
    endfunction
    // ****************
    // Scenarios
    // ****************
    initial
    begin
        #50000;
        num_errors = num_errors + 1;
        report_and_stop;
    end
    initial
    begin
        prev = 16'h0000;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        for (k = 0; k < 5; k = k + 1)
        begin
            rd(8'(4 * k), v);
            check(v, 32'h0);
        end
        check({15'h0, crc_error, crc_calc}, 32'h0);
        wr(8'h10, 32'h1f);
        wr(`WCM_ADDR_CTRL, 32'h1f);
        rd(`WCM_ADDR_CTRL, v);
        check(v, 32'h1f);
        rd(8'h10, v);
        check(v, 32'h0);
        // Byte and word modes, both nibble selects, mask on and off
        for (k = 0; k < 5; k = k + 1)
        begin
            ctl = CTRL_TAB[8*k +: 8];
            sel = SEL_TAB[k];
            bad = BAD_TAB[2*k +: 2];
            en = ctl[0] & ctl[1];
            tree = {144{1'b1}};
            bv = {180{1'b1}};
            for (b = 0; b < 4; b = b + 1)
            begin
                dq = 16'h3c5a ^ (16'h1b27 * b[15:0]) ^ {2{k[7:0]}};
                bv[18*b +: 18] = {b[1], b[0], dq};
                for (n = 0; n < 16; n = n + 1)
                    tree[8*(n+n/8)+4*sel+b] = dq[n];
                if (ctl[2] | ctl[3])
                begin
                    tree[64 + 4*sel + b] = b[0];
                    tree[136 + 4*sel + b] = b[1];
                end
            end
            lo = crc8(tree[71:0]);
            hi = crc8(tree[143:72]);
            chk = {hi, lo} ^ {7'h0, bad[1], 7'h0, bad[0]};
            bv[144 +: 18] = {2'h3, chk};
            wr(`WCM_ADDR_CTRL, {24'h0, ctl});
            @(posedge clk);
            {write_cmd, critical_nibble_select} <= {1'b1, sel};
            @(posedge clk);
            write_cmd <= 1'b0;
            err0 = err_seen;
            // Busy only shows while an accepted burst is in flight
            fork
                model_u.burst(bv);
                begin
                    repeat (4) @(posedge clk);
                    rd(`WCM_ADDR_STATUS, v);
                    check(v, {29'h0, en, 2'h0});
                end
            join
            repeat (8) @(posedge clk);
            check(err_seen - err0, {31'h0, en && bad != 2'h0});
            if (en)
                prev = ctl[4] ? {hi, lo} : {8'h00, lo};
            check({16'h0, crc_calc}, {16'h0, prev});
            rd(`WCM_ADDR_STATUS, v);
            check(v, {30'h0, bad & {2{en}}});
            wr(`WCM_ADDR_STATUS, 32'h3);
            rd(`WCM_ADDR_STATUS, v);
            check(v, 32'h0);
            rd(`WCM_ADDR_CRC_CALC, v);
            check(v, {16'h0, prev});
            if (en)
            begin
                rd(`WCM_ADDR_CRC_RECV, v);
                check(v, {16'h0, chk});
            end
        end
        report_and_stop;
    end
endmodule

//--- testbench/wcm_ctrl_model.sv
// Controller-side model that drives chopped write bursts
`timescale 1ns/1ps
module wcm_ctrl_model
(
    output reg link_strobe,
    output reg [15:0] link_dq,
    output reg lower_mask_inversion_lane,
    output reg upper_mask_inversion_lane
);
    // ****************
    // Burst driver
    // ****************
    integer b;
    initial
    begin
        link_strobe = 1'b0;
        {upper_mask_inversion_lane, lower_mask_inversion_lane} = 2'h0;
        link_dq = 16'h0000;
    end
    // Beat b is {upper mask, lower mask, lanes}; strobe idles low
    task burst(input [179:0] bv);
    begin
        // Step off the clock edge so no lane changes as it is sampled
        #1;
        for (b = 0; b < 10; b = b + 1)
        begin
            {upper_mask_inversion_lane, lower_mask_inversion_lane,
                link_dq} = bv[18*b +: 18];
            #31.25 link_strobe = 1'b1;
            #62.5 link_strobe = 1'b0;
            #31.25;
        end
        // Released lanes show the inverse, so stale data cannot pass
        {upper_mask_inversion_lane, lower_mask_inversion_lane,
            link_dq} = ~bv[162 +: 18];
    end
    endtask
endmodule

//--- testbench/wcm_mapper_checker.sv
// Port-level assertion checker for the write CRC mapper
`timescale 1ns/1ps
`include "wcm_regs.vh"
module wcm_mapper_checker
(
    input wire clk,
    input wire sys_rst,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    input wire [31:0] reg_rdata,
    input wire write_cmd,
    input wire critical_nibble_select,
    input wire link_strobe,
    input wire [15:0] link_dq,
    input wire lower_mask_inversion_lane,
    input wire upper_mask_inversion_lane,
    input wire crc_error,
    input wire [15:0] crc_calc
);
    // ****************
    // Helper state
    // ****************
    reg [2:0] stb_sync;
    reg [5:0] since_rise;
    reg [4:0] ctrl_q;
    wire bad_addr = reg_addr > `WCM_ADDR_CRC_RECV || reg_addr[1:0] != 2'h0;
    // Own strobe sync, so results are timed against a late edge view
    always @(posedge clk)
    begin
        stb_sync <= {stb_sync[1:0], link_strobe};
        if (sys_rst)
        begin
            since_rise <= 6'h3f;
            ctrl_q <= `WCM_CTRL_RESET;
        end
        else
        begin
            if (stb_sync[1] && !stb_sync[2])
                since_rise <= 6'h00;
            else if (since_rise != 6'h3f)
                since_rise <= since_rise + 6'h01;
            if (reg_write && reg_addr == `WCM_ADDR_CTRL)
                ctrl_q <= reg_wdata[4:0];
        end
    end
    // ****************
    // Assertions
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_ctrl_rd;
        reg_read && reg_addr == `WCM_ADDR_CTRL;
    endsequence
    AST_ERR_ONE_CYCLE: assert property (crc_error |=> !crc_error)
        else $error("error pulse too long");
    AST_ERR_AFTER_BEAT: assert property (
        crc_error |-> since_rise <= 6'h0c)
        else $error("error pulse without a burst");
    AST_CALC_AFTER_BEAT: assert property (
        $changed(crc_calc) |-> since_rise <= 6'h0c)
        else $error("check value moved without a burst");
    AST_ERR_NEEDS_EN: assert property (
        crc_error |-> ctrl_q[0] && ctrl_q[1])
        else $error("error pulse while mapping off");
    AST_X8_UPPER_ZERO: assert property (
        $changed(crc_calc) && !ctrl_q[4] |-> crc_calc[15:8] == 8'h00)
        else $error("upper check set in byte mode");
    AST_RDATA_IDLE: assert property (!reg_read |=> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    AST_CTRL_READBACK: assert property (
        s_ctrl_rd |=> reg_rdata == {27'h0, ctrl_q})
        else $error("control readback wrong");
    AST_UNMAPPED: assert property (reg_read && bad_addr |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
endmodule
bind wcm_write_crc_mapper wcm_mapper_checker chk_u (.clk(clk),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .write_cmd(write_cmd),
    .critical_nibble_select(critical_nibble_select),
    .link_strobe(link_strobe), .link_dq(link_dq),
    .lower_mask_inversion_lane(lower_mask_inversion_lane),
    .upper_mask_inversion_lane(upper_mask_inversion_lane),
    .crc_error(crc_error), .crc_calc(crc_calc));
